/* src/spi_slave_frame_port.sv */
// Framed 16-bit mode-0 serial slave port with short-frame detection.
// Assumes the master keeps the link clock low and still outside frames,
// and that the device logic supplies the answer bits and takes commands.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Frame spans select fall to select rise
// - Sample rising edge, shift out falling
// - Short frame dropped, error in next
// - Longer frames accepted for daisy chain
// - Deselected: ignore clock, output high impedance
// - Select fall loads answer into shifter
// - Sleep: output high impedance, no transfer
// - Select rise commits shifter to command
// - Clock high at select edge rejects
// - Both words travel MSB first
// - Single shifter, sixteen clocks per device
module spi_slave_frame_port import spi_frame_pkg::*; (
  input wire logic core_clk, // Core clock, 50 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes core state
  input wire logic sleep_mode, // Device is asleep
  input wire logic [RESP_W-1:0] resp_data, // Answer bits below flag
  input wire logic sclk, // Serial clock pin
  input wire logic select_low_pin, // Select pin, active low
  input wire logic mosi_in, // Serial data in pin
  output logic miso_out, // Serial data out pin
  output logic miso_oe_n, // Output enable, low drives
  output logic cmd_valid, // Committed command pulse
  output logic [FRAME_BITS-1:0] cmd_word, // Committed command
  output logic short_frame, // Short frame pulse
  output logic cmd_reject, // Clock-high reject pulse
  output logic err_pending // Error waits for next answer
);
  typedef struct packed {
    logic in_frame;
    logic sleep_frame;
    logic clk_bad;
    logic err_pend;
    logic [FRAME_BITS-1:0] load_word;
    logic cmd_valid;
    logic [FRAME_BITS-1:0] cmd_word;
    logic miso_oe_n;
    logic short_pulse;
    logic reject_pulse;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{
    in_frame: 1'b0,
    sleep_frame: 1'b0,
    clk_bad: 1'b0,
    err_pend: 1'b0,
    load_word: WORD_RESET,
    cmd_valid: 1'b0,
    cmd_word: WORD_RESET,
    miso_oe_n: 1'b1,
    short_pulse: 1'b0,
    reject_pulse: 1'b0
  };

  core_state_t r_reg;
  core_state_t r_next;

  logic sel_n_sync;
  logic sclk_sync;
  logic [FRAME_BITS-1:0] link_sr;
  logic [CNT_W-1:0] link_cnt;
  logic frame_start;
  logic frame_stop;

  // Select pin into the core domain
  sync_2ff #(
    .RST_VAL(SELECT_IDLE)
  ) u_sel_sync (
    .clk(core_clk),
    .srst(srst),
    .ce(ce),
    .d_in(select_low_pin),
    .q_out(sel_n_sync)
  );

  // Clock level, meaningful only near select edges where it is still
  sync_2ff #(
    .RST_VAL(SCLK_IDLE)
  ) u_sclk_sync (
    .clk(core_clk),
    .srst(srst),
    .ce(ce),
    .d_in(sclk),
    .q_out(sclk_sync)
  );

  // Shifter on the link clock
  spi_link_shift u_link (
    .sclk(sclk),
    .select_low_pin(select_low_pin),
    .mosi_in(mosi_in),
    .load_word(r_reg.load_word),
    .sr_out(link_sr),
    .cnt_out(link_cnt),
    .miso_out(miso_out)
  );

  // Frame edges as seen after synchronisation
  assign frame_start = !sel_n_sync && !r_reg.in_frame;
  assign frame_stop = sel_n_sync && r_reg.in_frame;

  // Frame bookkeeping; link words are still because the clock stopped
  always_comb begin
    r_next = r_reg;
    r_next.cmd_valid = 1'b0;
    r_next.short_pulse = 1'b0;
    r_next.reject_pulse = 1'b0;
    if (frame_start) begin
      r_next.in_frame = 1'b1;
      r_next.sleep_frame = sleep_mode;
      r_next.clk_bad = sclk_sync;
      if (!sleep_mode) begin
        // Answer word: pending error on top, device bits below
        r_next.load_word = {r_reg.err_pend, resp_data};
        r_next.err_pend = 1'b0;
      end
    end
    if (frame_stop) begin
      r_next.in_frame = 1'b0;
      if (!r_reg.sleep_frame) begin
        if (r_reg.clk_bad || sclk_sync) begin
          r_next.reject_pulse = 1'b1;
        end else if (link_cnt < FULL_COUNT) begin
          r_next.short_pulse = 1'b1;
          r_next.err_pend = 1'b1;
        end else begin
          r_next.cmd_valid = 1'b1;
          r_next.cmd_word = link_sr;
        end
      end
    end
    // Drive only while selected and awake
    r_next.miso_oe_n = !(!sel_n_sync && !r_next.sleep_frame);
  end

  // Register the core state; enable low freezes it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r_reg <= CORE_RESET;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign miso_oe_n = r_reg.miso_oe_n;
  assign cmd_valid = r_reg.cmd_valid;
  assign cmd_word = r_reg.cmd_word;
  assign short_frame = r_reg.short_pulse;
  assign cmd_reject = r_reg.reject_pulse;
  assign err_pending = r_reg.err_pend;

  // Checks on the core-side behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Committed frames carried at least a full word
  a_cmd_full_len: assert property (
    cmd_valid |-> link_cnt >= FULL_COUNT
  ) else $error("command committed from a short frame");

  // Short frame raises pending error and commits nothing
  a_short_sets_err: assert property (
    short_frame |-> err_pending && !cmd_valid
  ) else $error("short frame did not flag error");

  // Short frame was really short
  a_short_len: assert property (
    short_frame |-> link_cnt < FULL_COUNT
  ) else $error("full frame reported as short");

  // Commit copies the shifter
  a_cmd_copy: assert property (
    cmd_valid |-> cmd_word == link_sr
  ) else $error("command word differs from shifter");

  // Deselected output stays released
  a_idle_hiz: assert property (
    (sel_n_sync && !r_reg.in_frame) ##1 ce |-> miso_oe_n
  ) else $error("output driven while deselected");

  // Sleeping frames never drive and never commit
  a_sleep_quiet: assert property (
    r_reg.in_frame && r_reg.sleep_frame |->
      miso_oe_n ##1 !cmd_valid
  ) else $error("transfer during sleep");

  // Answer loads pending error at frame start
  a_load_err: assert property (
    ce && frame_start && !sleep_mode |=>
      r_reg.load_word[ERR_BIT] == $past(err_pending) && !err_pending
  ) else $error("answer not loaded at select fall");

  // Clock high at select rise gives a reject, not a command
  a_clk_reject: assert property (
    ce && frame_stop && !r_reg.sleep_frame && sclk_sync |=>
      cmd_reject && !cmd_valid
  ) else $error("clock high at select edge not rejected");

  // Command pulse lasts one cycle
  a_one_outcome: assert property (
    ce && cmd_valid |=> !cmd_valid [*2]
  ) else $error("command pulse repeated");

  // Only one kind of outcome at a time
  a_pulse_exclusive: assert property (
    $onehot0({cmd_valid, short_frame, cmd_reject})
  ) else $error("two frame outcomes at once");

  // Short-frame pulse lasts one cycle
  a_short_once: assert property (
    ce && short_frame |=> !short_frame [*2]
  ) else $error("short frame pulse repeated");

  // Reject pulse lasts one cycle
  a_reject_once: assert property (
    ce && cmd_reject |=> !cmd_reject [*2]
  ) else $error("reject pulse repeated");

  // A rejected command leaves the error flag alone
  a_reject_no_err: assert property (
    cmd_reject |-> err_pending == $past(err_pending)
  ) else $error("reject changed the error flag");

  // Error flag rises only with a short frame
  a_err_rise: assert property (
    $rose(err_pending) |-> short_frame
  ) else $error("error flag set without short frame");

  // Error flag clears only when it is loaded into an answer
  a_err_fall: assert property (
    $fell(err_pending) |-> $past(frame_start)
  ) else $error("error flag lost outside frame start");

  // Command word changes only with a commit
  a_word_hold: assert property (
    ce ##1 !cmd_valid |-> $stable(cmd_word)
  ) else $error("command word changed without commit");

  // Select rise releases the output
  a_oe_release: assert property (
    ce && frame_stop |=> miso_oe_n
  ) else $error("output still driven after frame end");

  // Awake frame drives the output while selected
  a_oe_drive: assert property (
    ce && r_reg.in_frame && !r_reg.sleep_frame && !sel_n_sync |=> !miso_oe_n
  ) else $error("output not driven inside frame");

  // Output is driven only inside a frame
  a_drive_in_frame: assert property (
    !miso_oe_n |-> r_reg.in_frame
  ) else $error("output driven outside a frame");

  // Sleeping frame ends without any outcome
  a_sleep_no_err: assert property (
    ce && frame_stop && r_reg.sleep_frame |=>
      !short_frame && !cmd_reject && !cmd_valid && err_pending == $past(err_pending)
  ) else $error("sleeping frame produced an outcome");

  // Sleeping frame keeps the previous answer word
  a_sleep_keeps_word: assert property (
    ce && frame_start && sleep_mode |=> $stable(r_reg.load_word)
  ) else $error("answer reloaded during sleep");

  // Commits come only from awake frames
  a_commit_awake: assert property (
    cmd_valid |-> !r_reg.sleep_frame
  ) else $error("command committed from sleeping frame");

  // Answer carries the device bits below the flag
  a_start_loads: assert property (
    ce && frame_start && !sleep_mode |=> r_reg.load_word[RESP_W-1:0] == $past(resp_data)
  ) else $error("answer bits not loaded at select fall");

  // Clock level at select fall is remembered
  a_start_clk_bad: assert property (
    ce && frame_start |=> r_reg.clk_bad == $past(sclk_sync)
  ) else $error("clock level at select fall lost");

  // Sleep state is latched for the whole frame
  a_sleep_latch: assert property (
    ce && frame_start |=> r_reg.sleep_frame == $past(sleep_mode)
  ) else $error("sleep state not latched at frame start");

  // Clock high at select fall rejects at frame end
  a_reject_stop: assert property (
    ce && frame_stop && !r_reg.sleep_frame && r_reg.clk_bad |=> cmd_reject
  ) else $error("clock high at select fall not rejected");

  // Short frame keeps the last committed word
  a_short_keeps_word: assert property (
    short_frame |-> cmd_word == $past(cmd_word)
  ) else $error("short frame changed the command word");

  // Rejected frame keeps the last committed word
  a_reject_keeps_word: assert property (
    cmd_reject |-> cmd_word == $past(cmd_word)
  ) else $error("rejected frame changed the command word");

  // No outcome without a frame to end
  a_idle_no_pulse: assert property (
    ce && !r_reg.in_frame |=> !cmd_valid && !short_frame && !cmd_reject
  ) else $error("outcome pulse outside a frame");

  // Frame tracking starts at select fall
  a_frame_enter: assert property (
    ce && frame_start |=> r_reg.in_frame
  ) else $error("frame start not tracked");

  // Frame tracking ends at select rise
  a_frame_leave: assert property (
    ce && frame_stop |=> !r_reg.in_frame
  ) else $error("frame end not tracked");

  // Main scenarios
  c_good_frame: cover property (cmd_valid);
  c_short_frame: cover property (short_frame ##[1:200] cmd_valid);
  c_rejected: cover property (cmd_reject);
  c_sleep_frame: cover property (r_reg.in_frame && r_reg.sleep_frame);
  c_err_answer: cover property (frame_start && r_reg.err_pend && !sleep_mode);
endmodule // spi_slave_frame_port
`default_nettype wire

/* src/spi_frame_pkg.sv */
// Shared constants for the framed serial slave port.
// Assumes a 16-bit mode-0 link and a 50 MHz core clock.
package spi_frame_pkg;
  // Word and counter geometry
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int MSB_POS = FRAME_BITS - 1;
  localparam int RESP_W = FRAME_BITS - 1;
  // Position of the short-frame error flag in the answer word
  localparam int ERR_BIT = 15;
  // Bit count at which a frame counts as complete
  localparam logic [CNT_W-1:0] FULL_COUNT = 5'h10;
  localparam logic [CNT_W-1:0] FIRST_COUNT = 5'h01;
  localparam logic [CNT_W-1:0] COUNT_STEP = 5'h01;
  // Reset values
  localparam logic [FRAME_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic SELECT_IDLE = 1'b1;
  localparam logic SCLK_IDLE = 1'b0;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage

/* src/sync_2ff.sv */
// Two-stage level synchroniser for pins entering the core clock domain.
// Assumes the input is a slow level or quiet around the moments it matters.
`timescale 1ns/100ps
`default_nettype none
module sync_2ff import spi_frame_pkg::*; #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk, // Core clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic d_in, // Asynchronous level
  output logic q_out // Synchronised level
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  // First stage feeds only the second one
  always_comb begin
    s_next.stage = {s_reg.stage[0], d_in};
  end

  // Register the chain
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg.stage <= {SYNC_STAGES{RST_VAL}};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign q_out = s_reg.stage[SYNC_STAGES-1];
endmodule // sync_2ff
`default_nettype wire

/* src/spi_link_shift.sv */
// Link-side shift register, clocked by the serial clock itself.
// Assumes the serial clock stands still and low outside frames.
`timescale 1ns/100ps
`default_nettype none
module spi_link_shift import spi_frame_pkg::*; (
  input wire logic sclk, // Serial clock from the master
  input wire logic select_low_pin, // Frame select, active low
  input wire logic mosi_in, // Serial data in
  input wire logic [FRAME_BITS-1:0] load_word, // Answer, stable in frame
  output logic [FRAME_BITS-1:0] sr_out, // Last bits shifted in
  output logic [CNT_W-1:0] cnt_out, // Saturating bit count
  output logic miso_out // Serial data out
);
  typedef struct packed {
    logic [FRAME_BITS-1:0] sr;
    logic [CNT_W-1:0] cnt;
  } link_state_t;

  link_state_t p_reg;
  link_state_t p_next;
  logic armed_reg;
  logic miso_reg;

  // Armed while deselected; first rising edge of a frame disarms
  always_ff @(posedge sclk or posedge select_low_pin) begin
    if (select_low_pin) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // One shift register: answer goes out, command comes in, MSB first
  always_comb begin
    p_next = p_reg;
    if (armed_reg) begin
      p_next.sr = {load_word[MSB_POS-1:0], mosi_in};
      p_next.cnt = FIRST_COUNT;
    end else begin
      p_next.sr = {p_reg.sr[MSB_POS-1:0], mosi_in};
      if (p_reg.cnt != FULL_COUNT) begin
        p_next.cnt = p_reg.cnt + COUNT_STEP;
      end
    end
  end

  // Sample on rising edge, only while selected
  always_ff @(posedge sclk) begin
    if (!select_low_pin) begin
      p_reg <= p_next;
    end
  end

  // Present next bit on falling edge
  always_ff @(negedge sclk) begin
    if (!select_low_pin) begin
      miso_reg <= p_reg.sr[MSB_POS];
    end
  end

  // Before the first edge the answer's top bit is already on the line
  assign miso_out = armed_reg ? load_word[MSB_POS] : miso_reg;
  assign sr_out = p_reg.sr;
  assign cnt_out = p_reg.cnt;
endmodule // spi_link_shift
`default_nettype wire

/* bench/spi_host_model.sv */
// Behavioural host that masters the framed serial link in mode 0.
// Assumes the caller spaces frames; the link clock runs only inside frames.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic sclk, // Serial clock, 6 ns period in frame
  output logic select_low_pin, // Frame select, active low
  output logic mosi_in, // Serial data to the port
  input wire logic miso_out // Serial data from the port
);
  // Idle link: select high, clock low
  initial begin
    sclk = 1'b0;
    select_low_pin = 1'b1;
    mosi_in = 1'b0;
  end
  // One frame of nb bits; hi leaves the clock high across select rise
  task automatic xfer(input logic [31:0] w, input int nb, input bit hi,
                      output logic [31:0] got);
    got = 32'h0;
    #100 select_low_pin = 1'b0;
    #100;
    for (int i = nb - 1; i >= 0; i--) begin
      mosi_in = w[i];
      #3 got = {got[30:0], miso_out};
      sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #100 sclk = hi;
    #20 select_low_pin = 1'b1;
    mosi_in = ~mosi_in; // Released line shows no stale bit
    #100 sclk = 1'b0;
    #140;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the framed serial slave port.
// Assumes the host model in its own file drives the link pins.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import spi_frame_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, ce = 1'b1, sleep_mode = 1'b0;
  logic [RESP_W-1:0] resp_data = 15'h0000;
  wire logic sclk, select_low_pin, mosi_in, miso_out, miso_oe_n;
  logic cmd_valid, short_frame, cmd_reject, err_pending;
  logic [FRAME_BITS-1:0] cmd_word;
  int n_errors = 0, n_compared = 0, cyc = 0, n_v, n_s, n_r, n_oe;
  logic [31:0] seed = 32'd63582;
  logic err_model = 1'b0;
  bit first = 1'b1;
  spi_slave_frame_port dut_u (.core_clk(core_clk), .srst(srst), .ce(ce),
    .sleep_mode(sleep_mode), .resp_data(resp_data), .sclk(sclk),
    .select_low_pin(select_low_pin), .mosi_in(mosi_in), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .short_frame(short_frame), .cmd_reject(cmd_reject), .err_pending(err_pending));
  spi_host_model host_u (.sclk(sclk), .select_low_pin(select_low_pin),
    .mosi_in(mosi_in), .miso_out(miso_out));
  always #10 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // Outcome pulses, drive cycles and the hang limit
  always @(negedge core_clk) begin
    cyc++;
    if (cmd_valid === 1'b1) n_v++;
    if (short_frame === 1'b1) n_s++;
    if (cmd_reject === 1'b1) n_r++;
    if (miso_oe_n === 1'b0) n_oe++;
    if (cyc > 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // One frame with its expected outcome worked out from the framing rules
  task automatic frame(input logic [31:0] w, input int nb, input bit hi, input bit slp);
    logic [31:0] got, msk;
    logic [15:0] ans;
    bit ok;
    @(posedge core_clk);
    ce <= 1'b0; // Frozen core must keep its state
    @(posedge core_clk);
    ce <= 1'b1;
    @(posedge core_clk);
    resp_data <= RESP_W'(rnd());
    sleep_mode <= slp;
    @(posedge core_clk);
    ans = {err_model, resp_data};
    n_v = 0;
    n_s = 0;
    n_r = 0;
    n_oe = 0;
    host_u.xfer(w, nb, hi, got);
    ok = !hi && !slp && nb >= 16;
    check("commit", {31'h0, ok}, n_v);
    check("short", {31'h0, !hi && !slp && nb < 16}, n_s);
    check("reject", {31'h0, hi && !slp}, n_r);
    check("drive", {31'h0, !slp}, {31'h0, n_oe > 0});
    check("idle_oe", 32'h1, {31'h0, miso_oe_n});
    if (ok) check("word", w & 32'hFFFF, {16'h0, cmd_word});
    if (!slp && nb >= 16 && !first) check("answer", ans, (got >> (nb - 16)) & 32'hFFFF);
    msk = (32'h1 << (nb - 16)) - 1;
    if (nb > 16) check("chain", (w >> 16) & msk, got & msk);
    if (!slp) err_model = (!hi && nb < 16);
    check("err_flag", {31'h0, err_model}, {31'h0, err_pending});
    if (!slp) first = 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < 6; k++) frame(rnd(), 16, 0, 0);
    frame(rnd(), 9, 0, 0);
    frame(rnd(), 1, 0, 0);
    frame(rnd(), 15, 0, 0);
    frame(32'h0000FFFF, 16, 0, 0);
    frame(rnd(), 24, 0, 0);
    frame(rnd(), 17, 0, 0);
    frame(rnd(), 16, 1, 0);
    frame(rnd(), 16, 0, 1);
    frame(32'h00008001, 16, 0, 0);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
